// >>> pkg/gtc_pkg.sv
// package for the pin, trigger and conversion configuration register bank
// assumes a byte-wide register port with single-cycle write and read strobes
package gtc_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h05; // second pin control
    localparam logic [7:0] ADDR_CONV_CFG = 8'h06; // pin conversion config
    localparam logic [7:0] ADDR_SEQ_ADDR = 8'h07; // sequence start address
    localparam logic [7:0] ADDR_FILTER = 8'h08; // digital filter config
    localparam logic [7:0] ADDR_CONV_CTRL = 8'h09; // converter control
    // ==========================================================
    // field positions
    localparam int DIR_LSB = 6; // direction 7:6
    localparam int ISEL_LSB = 4; // input select 5:4
    localparam int OSEL_LSB = 0; // output select 2:0
    localparam int DEST_LSB = 4; // destination 6:4
    localparam int CTYPE_LSB = 0; // conversion type 1:0
    localparam int FTYPE_LSB = 4; // filter type 5:4
    localparam int RATE_LSB = 0; // rate 3:0
    localparam int FRSV_BIT = 6; // reserved filter bit
    localparam int EXTERNAL_CLOCK_SELECT_BIT = 7;
    localparam int POL_BIT = 6;
    localparam int FMT_BIT = 5;
    localparam int RBP_BIT = 4;
    localparam int RBN_BIT = 3;
    localparam int REFSEL_LSB = 0; // reference select 2:0
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PIN_CTRL = 8'h00;
    localparam logic [7:0] RST_CONV_CFG = 8'h00;
    localparam logic [6:0] RST_SEQ_ADDR = 7'h3A;
    localparam logic [7:0] RST_FILTER = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL = 8'h01; // reference select 001
    // ==========================================================
    // limits and codes
    localparam logic [6:0] SEQ_ADDR_MIN = 7'h3A;
    localparam logic [6:0] SEQ_ADDR_MAX = 7'h6F;
    localparam logic [1:0] DIR_RSV = 2'h1;
    localparam logic [1:0] ISEL_RSV = 2'h3;
    localparam logic [1:0] ISEL_CONV = 2'h1;
    localparam logic [1:0] ISEL_SEQ = 2'h2;
    localparam logic [1:0] DIR_OD = 2'h2;
    localparam logic [1:0] DIR_PP = 2'h3;
    localparam int RES_WIDTH = 24; // result word width
    // ==========================================================
    // output selections
    typedef enum logic [2:0] {
        GTC_OUT_HIZ, GTC_OUT_INT_LOW, GTC_OUT_INT_HIGH, GTC_OUT_ZERO,
        GTC_OUT_ONE, GTC_OUT_SYSCLK, GTC_OUT_MOD_ACTIVE, GTC_OUT_LOW_SWITCH
    } gtc_osel_type;
endpackage : gtc_pkg

// >>> verilog/gtc_regs.sv
// register bank: second pin function, pin triggers, conversion format
// assumes pin input already synchronous to clk; sequencer, modulator and
// clock sources live outside and exchange simple levels and pulses here
//
// Function
// - reserved codes leave pin control unchanged
// - direction: input, open-drain, push-pull; 01 reserved
// - input select: off, conversion trigger, sequence trigger; 11 reserved
// - trigger in sleep: wake first, then start
// - output select codes zero through four
// - codes five-seven: clock, modulator, low switch
// - conversion config write starts nothing
// - pin conversion result goes to chosen register
// - conversion type: single, continuous, duty cycled
// - start address 3A to 6F, else ignored
// - address write launches nothing; trigger uses it
// - filter type selects FIR or sinc
// - rate field valid codes depend on filter
// - external clock takes over the first pin
// - clock select write ignored during sequence
// - polarity: one unipolar straight binary, zero bipolar
// - coding bit matters only in bipolar range
// - coding change leaves thresholds untouched
// - out-of-range results clamp to end codes
// - separate enables for both reference buffers
// - clock select at bit seven, resets internal
`timescale 1ns/10ps
module gtc_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // second pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // device status inputs
    input wire logic low_power_mode,
    input wire logic seq_running,
    input wire logic irq_level,
    input wire logic sys_clk_level,
    input wire logic mod_active,
    input wire logic low_switch_level,
    // raw result from the modulator path
    input wire logic raw_valid,
    input wire logic raw_over,
    input wire logic raw_under,
    input wire logic [gtc_pkg::RES_WIDTH-1:0] raw_code,
    // requests to the converter core
    output logic wake_req,
    output logic conv_start,
    output logic [1:0] conv_type,
    output logic [2:0] conv_dest,
    output logic seq_start,
    output logic [6:0] seq_addr,
    // configuration levels
    output logic [1:0] filter_type,
    output logic [3:0] rate_code,
    output logic ext_clock_sel,
    output logic first_pin_override,
    output logic polarity_select,
    output logic offset_binary,
    output logic pos_ref_buf_en,
    output logic neg_ref_buf_en,
    output logic [2:0] ref_select,
    // coded result
    output logic res_valid,
    output logic [gtc_pkg::RES_WIDTH-1:0] res_code
);
    import gtc_pkg::*;

    // ==========================================================
    // storage
    logic [7:0] pin_ctrl_ff; // second pin control
    logic [7:0] conv_cfg_ff; // pin conversion config
    logic [6:0] seq_addr_ff; // sequence start address
    logic [7:0] filter_ff; // digital filter config
    logic [7:0] ctrl_ff; // converter control
    logic pin_prev_ff; // last pin sample for edge find
    logic pend_conv_ff; // trigger waiting for wake
    logic pend_seq_ff;
    logic [7:0] nxt_pin_ctrl; // candidate pin control
    logic pin_rise;
    logic [1:0] wdir;
    logic [1:0] wisel;

    assign wdir = reg_wdata[DIR_LSB+:2];
    assign wisel = reg_wdata[ISEL_LSB+:2];
    assign pin_rise = pin_in & ~pin_prev_ff;

    // ==========================================================
    // second pin control, reserved codes refused whole
    always_comb begin
        nxt_pin_ctrl = pin_ctrl_ff;
        if (reg_wr && reg_addr == ADDR_PIN_CTRL && wdir != DIR_RSV && wisel != ISEL_RSV) begin
            nxt_pin_ctrl = {wdir, wisel, 1'b0, reg_wdata[OSEL_LSB+:3]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_ctrl_ff <= RST_PIN_CTRL;
        end else begin
            pin_ctrl_ff <= nxt_pin_ctrl;
        end
    end

    // ==========================================================
    // conversion config and sequence address; writes only store
    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_cfg_ff <= RST_CONV_CFG;
            seq_addr_ff <= RST_SEQ_ADDR;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CONV_CFG) begin
                conv_cfg_ff <= {1'b0, reg_wdata[DEST_LSB+:3], 2'b00, reg_wdata[CTYPE_LSB+:2]};
            end
            // out-of-range address leaves old value
            if (reg_addr == ADDR_SEQ_ADDR && reg_wdata[6:0] >= SEQ_ADDR_MIN
                    && reg_wdata[6:0] <= SEQ_ADDR_MAX) begin
                seq_addr_ff <= reg_wdata[6:0];
            end
        end
    end

    // ==========================================================
    // filter register; reserved bit kept as written, software keeps it zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            filter_ff <= RST_FILTER;
        end else if (reg_wr && reg_addr == ADDR_FILTER) begin
            filter_ff <= {1'b0, reg_wdata[FRSV_BIT], reg_wdata[FTYPE_LSB+:2], reg_wdata[RATE_LSB+:4]};
        end
    end

    // ==========================================================
    // converter control; clock select frozen while a sequence runs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff <= RST_CONV_CTRL;
        end else if (reg_wr && reg_addr == ADDR_CONV_CTRL) begin
            ctrl_ff[6:0] <= reg_wdata[6:0];
            if (!seq_running) begin
                ctrl_ff[EXTERNAL_CLOCK_SELECT_BIT] <= reg_wdata[EXTERNAL_CLOCK_SELECT_BIT];
            end
        end
    end

    // ==========================================================
    // read mux, unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_PIN_CTRL: reg_rdata <= pin_ctrl_ff;
                ADDR_CONV_CFG: reg_rdata <= conv_cfg_ff;
                ADDR_SEQ_ADDR: reg_rdata <= {1'b0, seq_addr_ff};
                ADDR_FILTER: reg_rdata <= filter_ff;
                ADDR_CONV_CTRL: reg_rdata <= ctrl_ff;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // trigger edges; driver holds pulses three clocks so one sample catches them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_prev_ff <= 1'b0;
            pend_conv_ff <= 1'b0;
            pend_seq_ff <= 1'b0;
            wake_req <= 1'b0;
            conv_start <= 1'b0;
            seq_start <= 1'b0;
        end else begin
            pin_prev_ff <= pin_in;
            conv_start <= 1'b0;
            seq_start <= 1'b0;
            wake_req <= 1'b0;
            // wake from low power first, fire only once back in normal mode
            if ((pend_conv_ff || pend_seq_ff) && low_power_mode) begin
                wake_req <= 1'b1;
            end else begin
                conv_start <= pend_conv_ff;
                seq_start <= pend_seq_ff;
                pend_conv_ff <= 1'b0;
                pend_seq_ff <= 1'b0;
            end
            // edge capture comes after the clear on purpose:
            // a fresh edge in the firing cycle must win over the clear,
            // otherwise the trigger would be dropped without a trace
            // edges only count while the pin is an input
            if (pin_ctrl_ff[DIR_LSB+:2] == 2'b00 && pin_rise) begin
                if (pin_ctrl_ff[ISEL_LSB+:2] == ISEL_CONV) begin
                    pend_conv_ff <= 1'b1;
                end
                if (pin_ctrl_ff[ISEL_LSB+:2] == ISEL_SEQ) begin
                    pend_seq_ff <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // pin driver
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            logic lvl;
            lvl = 1'b0;
            case (gtc_osel_type'(pin_ctrl_ff[OSEL_LSB+:3]))
                GTC_OUT_HIZ: lvl = 1'b0;
                GTC_OUT_INT_LOW: lvl = ~irq_level;
                GTC_OUT_INT_HIGH: lvl = irq_level;
                GTC_OUT_ZERO: lvl = 1'b0;
                GTC_OUT_ONE: lvl = 1'b1;
                GTC_OUT_SYSCLK: lvl = sys_clk_level;
                GTC_OUT_MOD_ACTIVE: lvl = mod_active;
                GTC_OUT_LOW_SWITCH: lvl = low_switch_level;
                default: lvl = 1'b0;
            endcase
            pin_out <= lvl;
            if (pin_ctrl_ff[DIR_LSB+:2] == DIR_PP && pin_ctrl_ff[OSEL_LSB+:3] == GTC_OUT_LOW_SWITCH) begin
                pin_oe <= ~lvl; // low switch overrides push-pull
            end else if (pin_ctrl_ff[OSEL_LSB+:3] == GTC_OUT_HIZ) begin
                pin_oe <= 1'b0;
            end else if (pin_ctrl_ff[DIR_LSB+:2] == DIR_PP) begin
                pin_oe <= 1'b1;
            end else if (pin_ctrl_ff[DIR_LSB+:2] == DIR_OD) begin
                pin_oe <= ~lvl;
            end else begin
                pin_oe <= 1'b0;
            end
        end
    end

    // ==========================================================
    // configuration outputs registered from storage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_type <= 2'b00;
            conv_dest <= 3'b000;
            seq_addr <= RST_SEQ_ADDR;
            filter_type <= 2'b00;
            rate_code <= 4'h0;
            ext_clock_sel <= 1'b0;
            first_pin_override <= 1'b0;
            polarity_select <= 1'b0;
            offset_binary <= 1'b0;
            pos_ref_buf_en <= 1'b0;
            neg_ref_buf_en <= 1'b0;
            ref_select <= RST_CONV_CTRL[2:0];
        end else begin
            conv_type <= conv_cfg_ff[CTYPE_LSB+:2];
            conv_dest <= conv_cfg_ff[DEST_LSB+:3];
            seq_addr <= seq_addr_ff;
            filter_type <= filter_ff[FTYPE_LSB+:2];
            rate_code <= filter_ff[RATE_LSB+:4];
            ext_clock_sel <= ctrl_ff[EXTERNAL_CLOCK_SELECT_BIT];
            first_pin_override <= ctrl_ff[EXTERNAL_CLOCK_SELECT_BIT];
            polarity_select <= ctrl_ff[POL_BIT];
            offset_binary <= ~ctrl_ff[POL_BIT] & ctrl_ff[FMT_BIT];
            pos_ref_buf_en <= ctrl_ff[RBP_BIT];
            neg_ref_buf_en <= ctrl_ff[RBN_BIT];
            ref_select <= ctrl_ff[REFSEL_LSB+:3];
        end
    end

    // ==========================================================
    // result coding with clamp; raw code is offset binary from the core
    always_ff @(posedge clk) begin
        if (!rstn) begin
            res_valid <= 1'b0;
            res_code <= '0;
        end else begin
            logic [RES_WIDTH-1:0] c;
            c = raw_code;
            if (raw_over) begin
                c = '1;
            end else if (raw_under) begin
                c = '0;
            end
            // two's complement only in bipolar range with coding bit low
            if (!ctrl_ff[POL_BIT] && !ctrl_ff[FMT_BIT]) begin
                c[RES_WIDTH-1] = ~c[RES_WIDTH-1];
            end
            res_valid <= raw_valid;
            res_code <= c;
        end
    end
endmodule : gtc_regs

// >>> tb/gtc_regs_props.sv
// checker for the register bank ports
// assumes it is bound onto gtc_regs, one clock domain
`timescale 1ns/10ps
module gtc_regs_props import gtc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // device status
    input wire logic low_power_mode,
    input wire logic seq_running,
    // raw result
    input wire logic raw_valid,
    input wire logic raw_over,
    input wire logic raw_under,
    input wire logic [RES_WIDTH-1:0] raw_code,
    // requests and levels
    input wire logic wake_req,
    input wire logic conv_start,
    input wire logic seq_start,
    input wire logic [6:0] seq_addr,
    input wire logic ext_clock_sel,
    input wire logic first_pin_override,
    input wire logic polarity_select,
    input wire logic offset_binary,
    // coded result
    input wire logic res_valid,
    input wire logic [RES_WIDTH-1:0] res_code
);
    // ==========================================
    // common clocking
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic tc; // two's complement in force
    assign tc = !polarity_select && !offset_binary;
    // ==========================================
    // assertions
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start held too long");
    wake_first_a: assert property (conv_start |-> !$past(low_power_mode))
        else $error("conversion started in low power");
    wake_cause_a: assert property (wake_req |-> $past(low_power_mode))
        else $error("wake request outside low power");
    seq_pulse_a: assert property (seq_start |=> !seq_start)
        else $error("sequence start held too long");
    addr_range_a: assert property (seq_addr >= SEQ_ADDR_MIN && seq_addr <= SEQ_ADDR_MAX)
        else $error("start address out of range");
    clock_hold_a: assert property (seq_running [*3] |-> $stable(ext_clock_sel))
        else $error("clock source changed in sequence");
    pin_override_a: assert property (first_pin_override == ext_clock_sel)
        else $error("first pin override mismatch");
    result_next_a: assert property (raw_valid |=> res_valid)
        else $error("result not delivered");
    clamp_high_a: assert property (raw_valid && raw_over |=> res_code == (tc ? 24'h7FFFFF : 24'hFFFFFF))
        else $error("high clamp wrong");
    clamp_low_a: assert property (raw_valid && raw_under && !raw_over |=> res_code == (tc ? 24'h800000 : 24'h0))
        else $error("low clamp wrong");
    coding_map_a: assert property (raw_valid && !raw_over && !raw_under
        |=> res_code == ($past(raw_code) ^ {tc, 23'h0}))
        else $error("result coding wrong");
    // ==========================================
    // covers
    conv_c: cover property (conv_start);
    seq_c: cover property (seq_start);
    wake_c: cover property (wake_req);
endmodule : gtc_regs_props
bind gtc_regs gtc_regs_props i_props (
    .clk(clk), .rstn(rstn), .low_power_mode(low_power_mode), .seq_running(seq_running),
    .raw_valid(raw_valid), .raw_over(raw_over), .raw_under(raw_under), .raw_code(raw_code),
    .wake_req(wake_req), .conv_start(conv_start), .seq_start(seq_start), .seq_addr(seq_addr),
    .ext_clock_sel(ext_clock_sel), .first_pin_override(first_pin_override),
    .polarity_select(polarity_select), .offset_binary(offset_binary),
    .res_valid(res_valid), .res_code(res_code)
);

// >>> tb/gtc_pin_partner.sv
// partner model: external logic on the second pin
// assumes the bench calls pulse; wire has no pull
`timescale 1ns/10ps
module gtc_pin_partner (
    // clock
    input wire logic clk,
    // device pin drive
    input wire logic pin_out,
    input wire logic pin_oe,
    // level seen by the device
    output logic pin_in
);
    // ==========================================
    // external drive, held low between pulses
    logic ext_level = 1'b0;
    // wire follows the device when it drives
    assign pin_in = pin_oe ? pin_out : ext_level;
    // three clocks high, two above the one-clock minimum
    task automatic pulse();
        @(posedge clk);
        #1;
        ext_level = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        ext_level = 1'b0;
    endtask : pulse
endmodule : gtc_pin_partner

// >>> tb/gtc_regs_test.sv
// self-checking bench for the register bank
// assumes the pin partner and the bound checker
`timescale 1ns/10ps
module gtc_regs_test;
    import gtc_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic clk, rstn, wr, rd, lpm, srun, irq, sclk, mod, lsw, rv, ro, ru, pin, po, poe, wake, cs, ss;
    logic ext, fpo, pol, obin, pb, nb, resv;
    logic [7:0] addr, wdata, rdata;
    logic [23:0] raw, res;
    logic [1:0] ctype, ftype;
    logic [2:0] dest, rsel;
    logic [6:0] saddr;
    logic [3:0] rate;
    int bad_count = 0, compares = 0, n_conv = 0, n_seq = 0, n_wake = 0, cyc = 0;
    // ==========================================
    // design and partner
    gtc_regs i_dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .pin_in(pin), .pin_out(po), .pin_oe(poe),
        .low_power_mode(lpm), .seq_running(srun), .irq_level(irq), .sys_clk_level(sclk),
        .mod_active(mod), .low_switch_level(lsw), .raw_valid(rv), .raw_over(ro), .raw_under(ru),
        .raw_code(raw), .wake_req(wake), .conv_start(cs), .conv_type(ctype), .conv_dest(dest),
        .seq_start(ss), .seq_addr(saddr), .filter_type(ftype), .rate_code(rate),
        .ext_clock_sel(ext), .first_pin_override(fpo), .polarity_select(pol),
        .offset_binary(obin), .pos_ref_buf_en(pb), .neg_ref_buf_en(nb), .ref_select(rsel),
        .res_valid(resv), .res_code(res));
    gtc_pin_partner i_pin (.clk(clk), .pin_out(po), .pin_oe(poe), .pin_in(pin));
    // ==========================================
    // clock and event counters, sampled off the edge
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        n_conv += int'(cs === 1'b1);
        n_seq += int'(ss === 1'b1);
        n_wake += int'(wake === 1'b1);
        if (cyc == 3000) begin
            bad_count++;
            $display("ERROR %0t run too long", $time);
            end_of_test();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        addr = a;
        wdata = d;
        wr = 1;
        tick(1);
        wr = 0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        addr = a;
        rd = 1;
        tick(1);
        rd = 0;
        tick(1);
        chk(rdata, e);
    endtask : rreg
    task automatic result(input logic o, input logic u, input logic [23:0] e);
        tick(1);
        {rv, ro, ru, raw} = {1'b1, o, u, 24'h800005};
        tick(1);
        rv = 0;
        chk({resv, res}, {1'b1, e});
    endtask : result
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // ==========================================
    // main sequence
    initial begin
        {rstn, wr, rd, lpm, srun, rv, ro, ru, addr, wdata, raw} = '0;
        {irq, sclk, mod, lsw} = 4'b1100;
        tick(8);
        rstn = 1;
        // reset values, unmapped offset reads zero
        for (int i = 0; i < 5; i++) rreg(8'h05 + 8'(i), 8'(40'h01_00_3A_00_00 >> (8 * i)));
        rreg(8'h0A, 8'h00);
        chk(saddr, 7'h3A);
        chk(rsel, 3'h1);
        $display("reset values done");
        // reserved codes and bit 3 leave 83 in place
        for (int i = 3; i >= 0; i--) begin
            wreg(ADDR_PIN_CTRL, 8'(32'h83_43_B3_8B >> (8 * i)));
            rreg(ADDR_PIN_CTRL, 8'h83);
        end
        $display("pin control done");
        // every output select in push-pull
        for (int i = 0; i < 8; i++) begin
            wreg(ADDR_PIN_CTRL, 8'hC0 | 8'(i));
            tick(2);
            chk(poe, 1'(i != 0));
            if (i != 0) chk(po, 1'(8'h34 >> i));
        end
        wreg(ADDR_PIN_CTRL, 8'h84);
        tick(2);
        chk(poe, 1'b0);
        wreg(ADDR_PIN_CTRL, 8'h83);
        tick(2);
        chk({poe, po}, 2'b10);
        $display("pin outputs done");
        // every destination and type; write alone starts nothing
        wreg(ADDR_PIN_CTRL, 8'h10);
        for (int k = 0; k < 8; k++) begin
            wreg(ADDR_CONV_CFG, {1'b0, 3'(k), 2'b00, 2'(k)});
            tick(2);
            chk(n_conv, k);
            i_pin.pulse();
            tick(2);
            chk(n_conv, k + 1);
            chk({dest, ctype}, {3'(k), 2'(k)});
        end
        lpm = 1;
        i_pin.pulse();
        tick(4);
        chk(n_conv, 8);
        chk(1'(n_wake > 0), 1'b1);
        lpm = 0;
        tick(3);
        chk(n_conv, 9);
        $display("conversion trigger done");
        // start address range, then sequencer trigger
        for (int i = 3; i >= 0; i--) begin
            wreg(ADDR_SEQ_ADDR, 8'(32'h39_70_6F_EF >> (8 * i)));
            rreg(ADDR_SEQ_ADDR, (i > 1) ? 8'h3A : 8'h6F);
        end
        chk({n_seq, saddr}, 7'h6F);
        wreg(ADDR_PIN_CTRL, 8'h20);
        i_pin.pulse();
        tick(2);
        chk({n_seq, n_conv}, {32'd1, 32'd9});
        $display("sequence trigger done");
        // filter type and rate
        for (int f = 0; f < 4; f++) begin
            wreg(ADDR_FILTER, {2'b00, 2'(f), 4'(f + 9)});
            rreg(ADDR_FILTER, {2'b00, 2'(f), 4'(f + 9)});
            chk({ftype, rate}, {2'(f), 4'(f + 9)});
        end
        $display("filter done");
        // clock, range, coding and buffers
        wreg(ADDR_CONV_CTRL, 8'hF8);
        rreg(ADDR_CONV_CTRL, 8'hF8);
        chk({ext, fpo, pol, obin, pb, nb}, 6'h3B);
        chk(rsel, 3'h0);
        wreg(ADDR_CONV_CTRL, 8'h10);
        rreg(ADDR_CONV_CTRL, 8'h10);
        chk({ext, fpo, pb, nb}, 4'h2);
        srun = 1;
        wreg(ADDR_CONV_CTRL, 8'h88);
        rreg(ADDR_CONV_CTRL, 8'h08);
        srun = 0;
        for (int m = 0; m < 4; m++) begin
            wreg(ADDR_CONV_CTRL, {1'b0, 2'(m), 5'h0});
            tick(2);
            result(0, 0, (m == 0) ? 24'h000005 : 24'h800005);
            result(1, 0, (m == 0) ? 24'h7FFFFF : 24'hFFFFFF);
            result(0, 1, (m == 0) ? 24'h800000 : 24'h000000);
        end
        $display("control and coding done");
        end_of_test();
    end
endmodule : gtc_regs_test
